/* simd_vector_register_state.sv */
// Purpose: architectural state of the single-precision SIMD extension
// Assumes: requests from the pipeline are synchronous to CLOCK_I
// Notes:   arithmetic, exception delivery and cache control stay outside
//          store image bytes past the transfer length read as zero
//          a bad control write keeps the register; an exception in that cycle still sets flags
`timescale 1ns/10ps
module simd_vector_register_state
  import simd_state_pkg::*;
#(
  parameter bit DENORM_ZERO_SUPPORTED = 1'b1
) (
  input  wire logic                              CLOCK_I,
  input  wire logic                              RESETN_I,
  // vector register write and read
  input  wire simd_state_pkg::vec_wr_s           VEC_WR_I,
  input  wire simd_state_pkg::vec_rd_s           VEC_RD_I,
  output logic [simd_state_pkg::VEC_W-1:0]       VEC_RD_DATA_O,
  // memory store image, byte 0 is lowest address
  output logic [simd_state_pkg::VEC_W-1:0]       STORE_BYTES_O,
  output logic [simd_state_pkg::BYTES_W-1:0]     STORE_LEN_O,
  // control register load / restore / read
  input  wire simd_state_pkg::cs_op_e            CS_OP_I,
  input  wire logic [simd_state_pkg::CSR_W-1:0]  CS_WR_DATA_I,
  input  wire logic                              EXC_SET_I,
  input  wire logic [5:0]                        EXC_FLAGS_I,
  output logic [simd_state_pkg::CSR_W-1:0]       CS_RD_DATA_O,
  output logic                                   GP_FAULT_O,
  output logic [1:0]                             ROUND_CTRL_O,
  output logic                                   FLUSH_ZERO_O,
  output logic                                   DENORM_ZERO_O,
  output logic [5:0]                             EXC_MASK_O,
  output logic [5:0]                             EXC_FLAG_O,
  // compare result onto flags register
  input  wire logic                              CMP_VALID_I,
  input  wire logic [simd_state_pkg::FLG_W-1:0]  CMP_FLAGS_I,
  output logic [simd_state_pkg::FLG_W-1:0]       FLAGS_REG_O,
  // packed-integer registers
  input  wire simd_state_pkg::pi_wr_s            PI_WR_I,
  input  wire logic [simd_state_pkg::IDX_W-1:0]  PI_RD_IDX_I,
  output logic [simd_state_pkg::PI_W-1:0]        PI_RD_DATA_O,
  // general-purpose operand registers
  input  wire simd_state_pkg::gp_wr_s            GP_WR_I,
  input  wire logic [simd_state_pkg::IDX_W-1:0]  GP_RD_IDX_I,
  output logic [simd_state_pkg::GP_W-1:0]        GP_RD_DATA_O
);
  import simd_state_pkg::*;

  // ==========================================================================
  // storage
  logic [VEC_W-1:0] vec_ff [NUM_VEC];
  logic [PI_W-1:0]  pi_ff  [NUM_VEC];
  logic [GP_W-1:0]  gp_ff  [NUM_VEC];
  logic [CSR_W-1:0] csr_ff;
  logic [FLG_W-1:0] flags_ff;
  logic [VEC_W-1:0] rd_data_ff;
  logic [VEC_W-1:0] store_ff;
  logic [BYTES_W-1:0] store_len_ff;
  logic [PI_W-1:0]  pi_rd_ff;
  logic [GP_W-1:0]  gp_rd_ff;
  logic             gp_fault_ff;
  logic [VEC_W-1:0] vec_sel;
  logic             cs_write;
  logic             cs_bad;
  logic [CSR_W-1:0] nxt_csr;
  logic [FLG_W-1:0] nxt_flags;
  logic             rsv_bad;
  logic             denorm_bad;
  logic [CSR_W-1:0] exc_bits;
  wire  logic [NUM_VEC-1:0] vec_wen;
  wire  logic [NUM_VEC-1:0] pi_wen;
  wire  logic [NUM_VEC-1:0] gp_wen;
  wire  logic [VEC_W-1:0]   store_img;

  localparam int BYTE_W    = 8;
  localparam int NUM_BYTES = VEC_W / BYTE_W;

  // ==========================================================================
  // write decode, one enable per register slot
  genvar g;
  generate
    for (g = 0; g < NUM_VEC; g++) begin : g_dec
      assign vec_wen[g] = VEC_WR_I.en && (VEC_WR_I.idx == IDX_W'(g));
      assign pi_wen[g]  = PI_WR_I.en && (PI_WR_I.idx == IDX_W'(g));
      assign gp_wen[g]  = GP_WR_I.en && (GP_WR_I.idx == IDX_W'(g));
    end
  endgenerate

  // ==========================================================================
  // vector registers, one private slot per index
  // untouched lanes keep their value on the narrow widths
  generate
    for (g = 0; g < NUM_VEC; g++) begin : g_vec
      always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          vec_ff[g] <= '0;
        end else if (vec_wen[g]) begin
          unique case (VEC_WR_I.width)
            W_32: begin
              vec_ff[g][31:0] <= VEC_WR_I.data[31:0];
            end
            W_64: begin
              vec_ff[g][63:0] <= VEC_WR_I.data[63:0];
            end
            W_128: begin
              vec_ff[g] <= VEC_WR_I.data;
            end
            default: begin
              vec_ff[g] <= vec_ff[g];
            end
          endcase
        end
      end
    end
  endgenerate

  // ==========================================================================
  // vector read and memory store image
  // read data goes only to operand and store paths, never to addressing
  always_comb begin
    vec_sel = vec_ff[VEC_RD_I.idx];
  end

  // read data: low lanes of the selected register, upper lanes zero for W_32 and W_64; W_128 returns the whole register
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rd_data_ff <= '0;
    end else if (VEC_RD_I.en) begin
      unique case (VEC_RD_I.width)
        W_32: begin
          rd_data_ff <= {ZERO64, ZERO32, vec_sel[31:0]};
        end
        W_64: begin
          rd_data_ff <= {ZERO64, vec_sel[63:0]};
        end
        default: begin
          rd_data_ff <= vec_sel;
        end
      endcase
    end
  end

  // byte count of the memory transfer that goes with the read
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      store_len_ff <= '0;
    end else if (VEC_RD_I.en) begin
      unique case (VEC_RD_I.width)
        W_32: begin
          store_len_ff <= SZ_32;
        end
        W_64: begin
          store_len_ff <= SZ_64;
        end
        default: begin
          store_len_ff <= SZ_128;
        end
      endcase
    end
  end

  // full copy of the register; the byte lanes below trim it to the length
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      store_ff <= '0;
    end else if (VEC_RD_I.en) begin
      store_ff <= vec_sel;
    end
  end

  assign VEC_RD_DATA_O = rd_data_ff;
  assign STORE_LEN_O   = store_len_ff;

  // ==========================================================================
  // memory store image
  // byte k goes to address base+k: least significant byte first
  generate
    for (g = 0; g < NUM_BYTES; g++) begin : g_store_byte
      assign store_img[BYTE_W*g +: BYTE_W] =
        (BYTES_W'(g) < store_len_ff) ? store_ff[BYTE_W*g +: BYTE_W]
                                     : '0;
    end
  endgenerate

  assign STORE_BYTES_O = store_img;

  // ==========================================================================
  // control and status register
  always_comb begin
    cs_write = (CS_OP_I == CS_LOAD) || (CS_OP_I == CS_RESTORE);
  end

  // reserved bits must arrive as zero; bit 6 only where the mode exists
  always_comb begin
    rsv_bad    = (CS_WR_DATA_I & CSR_RSV) != '0;
    denorm_bad = !DENORM_ZERO_SUPPORTED
                 && CS_WR_DATA_I[DENORM_ZERO_BIT];
    cs_bad     = cs_write && (rsv_bad || denorm_bad);
  end

  // detected exceptions land in the flag bits only
  always_comb begin
    exc_bits = '0;
    if (EXC_SET_I) begin
      exc_bits[EXC_FLAG_HI:EXC_FLAG_LO] = EXC_FLAGS_I;
    end
  end

  always_comb begin
    nxt_csr = csr_ff;
    if (cs_write && !cs_bad) begin
      nxt_csr = CS_WR_DATA_I;
    end
    // hardware exception detection sets flags; set wins over a clear
    nxt_csr = nxt_csr | (exc_bits & FLAG_MSK);
    // a mask/flag change here never signals anything outward
    nxt_csr = nxt_csr & ~CSR_RSV;
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      csr_ff <= CSR_RESET;
    end else begin
      csr_ff <= nxt_csr;
    end
  end

  // ==========================================================================
  // fault pulse, one cycle after a refused write
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      gp_fault_ff <= 1'b0;
    end else begin
      gp_fault_ff <= cs_bad;
    end
  end

  assign GP_FAULT_O    = gp_fault_ff;

  // ==========================================================================
  // control register read and field outputs
  assign CS_RD_DATA_O  = csr_ff & ~CSR_RSV;
  assign EXC_FLAG_O    = csr_ff[EXC_FLAG_HI:EXC_FLAG_LO];
  assign EXC_MASK_O    = csr_ff[EXC_MASK_HI:EXC_MASK_LO];
  assign ROUND_CTRL_O  = csr_ff[ROUND_HI:ROUND_LO];
  assign FLUSH_ZERO_O  = csr_ff[FTZ_BIT];
  assign DENORM_ZERO_O = csr_ff[DENORM_ZERO_BIT];

  // ==========================================================================
  // flags register updated by compares
  always_comb begin
    nxt_flags = flags_ff;
    if (CMP_VALID_I) begin
      nxt_flags = CMP_FLAGS_I;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign FLAGS_REG_O = flags_ff;

  // ==========================================================================
  // packed-integer registers
  generate
    for (g = 0; g < NUM_VEC; g++) begin : g_pi
      always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          pi_ff[g] <= '0;
        end else if (pi_wen[g]) begin
          pi_ff[g] <= PI_WR_I.data;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // general-purpose operand registers
  generate
    for (g = 0; g < NUM_VEC; g++) begin : g_gp
      always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          gp_ff[g] <= '0;
        end else if (gp_wen[g]) begin
          gp_ff[g] <= GP_WR_I.data;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // operand read ports, index sampled every edge
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pi_rd_ff <= '0;
    end else begin
      pi_rd_ff <= pi_ff[PI_RD_IDX_I];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      gp_rd_ff <= '0;
    end else begin
      gp_rd_ff <= gp_ff[GP_RD_IDX_I];
    end
  end

  assign PI_RD_DATA_O = pi_rd_ff;
  assign GP_RD_DATA_O = gp_rd_ff;

  // ==========================================================================
  // execution modes
  // no execution-mode input gates any path: all state works in every mode

endmodule : simd_vector_register_state

/* simd_state_pkg.sv */
// Purpose: shared constants and carriers for the vector register state
// Assumes: one core clock, pipeline drives requests synchronously
// Notes:   control register field layout and reset values live here
package simd_state_pkg;

  // ==========================================================================
  // sizes
  localparam int VEC_W   = 128;
  localparam int NUM_VEC = 8;
  localparam int IDX_W   = 3;
  localparam int CSR_W   = 32;
  localparam int PI_W    = 64;
  localparam int GP_W    = 32;
  localparam int FLG_W   = 32;
  localparam int BYTES_W = 5;

  // ==========================================================================
  // control register field positions
  localparam int EXC_FLAG_LO = 0;
  localparam int EXC_FLAG_HI = 5;
  localparam int DENORM_ZERO_BIT = 6;
  localparam int EXC_MASK_LO = 7;
  localparam int EXC_MASK_HI = 12;
  localparam int ROUND_LO    = 13;
  localparam int ROUND_HI    = 14;
  localparam int FTZ_BIT     = 15;
  localparam int RSV_LO      = 16;
  localparam int RSV_HI      = 31;

  // reset value: masks set, everything else clear
  localparam logic [CSR_W-1:0] CSR_RESET = 32'h0000_1f80;
  localparam logic [CSR_W-1:0] CSR_RSV   = 32'hffff_0000;
  localparam logic [CSR_W-1:0] DENORM_ZERO_MSK = 32'h0000_0040;
  localparam logic [CSR_W-1:0] FLAG_MSK  = 32'h0000_003f;

  // transfer sizes in bytes
  localparam logic [BYTES_W-1:0] SZ_32  = 5'h04;
  localparam logic [BYTES_W-1:0] SZ_64  = 5'h08;
  localparam logic [BYTES_W-1:0] SZ_128 = 5'h10;

  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [63:0] ZERO64 = 64'h0000_0000_0000_0000;

  // ==========================================================================
  // vector access widths
  typedef enum logic [1:0] {
    W_32  = 2'h0,
    W_64  = 2'h1,
    W_128 = 2'h2
  } width_e;

  // control register operations
  typedef enum logic [1:0] {
    CS_NONE    = 2'h0,
    CS_LOAD    = 2'h1,
    CS_RESTORE = 2'h2
  } cs_op_e;

  typedef struct packed {
    logic             en;
    logic [IDX_W-1:0] idx;
    width_e           width;
    logic [VEC_W-1:0] data;
  } vec_wr_s;

  typedef struct packed {
    logic             en;
    logic [IDX_W-1:0] idx;
    width_e           width;
  } vec_rd_s;

  typedef struct packed {
    logic             en;
    logic [IDX_W-1:0] idx;
    logic [PI_W-1:0]  data;
  } pi_wr_s;

  typedef struct packed {
    logic             en;
    logic [IDX_W-1:0] idx;
    logic [GP_W-1:0]  data;
  } gp_wr_s;

endpackage : simd_state_pkg

/* simd_state_chk.sv */
// Purpose: port checks for the vector register state
// Assumes: one clock, asynchronous active-low reset
// Notes:   attached by the bind after the module
`timescale 1ns/10ps
module simd_state_chk
  import simd_state_pkg::*;
(
  input wire logic                   CLOCK_I,
  input wire logic                   RESETN_I,
  input wire simd_state_pkg::vec_rd_s VEC_RD_I,
  input wire logic [4:0]             STORE_LEN_O,
  input wire simd_state_pkg::cs_op_e CS_OP_I,
  input wire logic [31:0]            CS_WR_DATA_I,
  input wire logic                   EXC_SET_I,
  input wire logic [5:0]             EXC_FLAGS_I,
  input wire logic [31:0]            CS_RD_DATA_O,
  input wire logic                   GP_FAULT_O,
  input wire logic [1:0]             ROUND_CTRL_O,
  input wire logic                   FLUSH_ZERO_O,
  input wire logic                   DENORM_ZERO_O,
  input wire logic [5:0]             EXC_MASK_O,
  input wire logic [5:0]             EXC_FLAG_O,
  input wire logic                   CMP_VALID_I,
  input wire logic [31:0]            CMP_FLAGS_I,
  input wire logic [31:0]            FLAGS_REG_O
);
  logic wr_req;
  logic bad_req;
  assign wr_req  = CS_OP_I inside {CS_LOAD, CS_RESTORE};
  assign bad_req = wr_req && (|CS_WR_DATA_I[31:16]);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  // ==========================================================================
  // sequences
  sequence s_bad;
    bad_req;
  endsequence
  sequence s_pulse;
    GP_FAULT_O ##1 !GP_FAULT_O;
  endsequence
  // ==========================================================================
  // assertions
  a_rsv_read_zero: assert property (CS_RD_DATA_O[31:16] == 16'h0000)
    else $error("reserved control bits read nonzero");
  a_bad_load_fault: assert property (s_bad |=> s_pulse)
    else $error("no single fault pulse after bad load");
  a_fault_no_update: assert property (bad_req && !EXC_SET_I |=>
    CS_RD_DATA_O == $past(CS_RD_DATA_O)) else $error("bad load changed csr");
  a_good_load_takes: assert property (wr_req && !bad_req && !EXC_SET_I |=>
    CS_RD_DATA_O == $past(CS_WR_DATA_I) && !GP_FAULT_O)
    else $error("good load not taken");
  a_fields_follow: assert property (ROUND_CTRL_O == CS_RD_DATA_O[14:13] &&
    FLUSH_ZERO_O == CS_RD_DATA_O[15] && DENORM_ZERO_O == CS_RD_DATA_O[6] &&
    EXC_MASK_O == CS_RD_DATA_O[12:7] && EXC_FLAG_O == CS_RD_DATA_O[5:0])
    else $error("field outputs differ from csr");
  a_csr_holds: assert property (!wr_req && !EXC_SET_I |=> $stable(CS_RD_DATA_O))
    else $error("csr changed without a write");
  a_flags_or: assert property (EXC_SET_I && !wr_req |=> EXC_FLAG_O ==
    ($past(EXC_FLAG_O) | $past(EXC_FLAGS_I))) else $error("flags not ored");
  a_cmp_flags: assert property (CMP_VALID_I |=> FLAGS_REG_O == $past(CMP_FLAGS_I))
    else $error("flags register not loaded");
  a_store_len: assert property (VEC_RD_I.en |=> STORE_LEN_O ==
    ($past(VEC_RD_I.width) == W_32 ? SZ_32 :
     $past(VEC_RD_I.width) == W_64 ? SZ_64 : SZ_128))
    else $error("store length wrong");
endmodule : simd_state_chk
bind simd_vector_register_state simd_state_chk simd_state_chk_inst (.*);

/* store_sink_model.sv */
// Purpose: memory side that takes the store image of a read
// Assumes: image valid one edge after the read request
// Notes:   bytes beyond the length show the inverse of the old byte
`timescale 1ns/10ps
module store_sink_model (
  input  wire logic         clk_i,
  input  wire logic         rd_en_i,
  input  wire logic [127:0] bytes_i,
  input  wire logic [4:0]   len_i,
  output logic [7:0]        mem_o [16]
);
  logic en_d;
  always_ff @(posedge clk_i) begin
    en_d <= rd_en_i;
    if (en_d) begin
      for (int k = 0; k < 16; k++) begin
        mem_o[k] <= (k < len_i) ? bytes_i[8*k +: 8] : ~mem_o[k];
      end
    end
  end
endmodule : store_sink_model

/* tb.sv */
// Purpose: self-checking bench for the vector register state
// Assumes: inputs driven at the falling edge
// Notes:   one idle cycle between requests
`timescale 1ns/10ps
module tb;
  import simd_state_pkg::*;
  logic CLOCK_I = 1'b0, RESETN_I = 1'b0, EXC_SET_I, CMP_VALID_I;
  logic GP_FAULT_O, FLUSH_ZERO_O, DENORM_ZERO_O;
  vec_wr_s VEC_WR_I;
  vec_rd_s VEC_RD_I;
  cs_op_e  CS_OP_I;
  pi_wr_s  PI_WR_I;
  gp_wr_s  GP_WR_I;
  logic [127:0] VEC_RD_DATA_O, STORE_BYTES_O, ramp;
  logic [63:0]  PI_RD_DATA_O;
  logic [31:0]  CS_WR_DATA_I, CS_RD_DATA_O, CMP_FLAGS_I, FLAGS_REG_O, GP_RD_DATA_O;
  logic [5:0]   EXC_FLAGS_I, EXC_MASK_O, EXC_FLAG_O;
  logic [4:0]   STORE_LEN_O;
  logic [2:0]   PI_RD_IDX_I, GP_RD_IDX_I;
  logic [1:0]   ROUND_CTRL_O;
  logic [7:0]   mem [16];
  int           err_count = 0, total_checks = 0;
  always #50 CLOCK_I = ~CLOCK_I;
  simd_vector_register_state simd_vector_register_state_inst (.*);
  store_sink_model store_sink_model_inst (.clk_i(CLOCK_I),
    .rd_en_i(VEC_RD_I.en), .bytes_i(STORE_BYTES_O), .len_i(STORE_LEN_O),
    .mem_o(mem));
  // ==========================================================================
  // tasks
  task automatic chk(input string n, input logic [127:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic vwr(input logic [2:0] i, input width_e w, input logic [127:0] d);
    @(negedge CLOCK_I) VEC_WR_I = {1'b1, i, w, d};
    @(negedge CLOCK_I) VEC_WR_I.en = 1'b0;
  endtask : vwr
  task automatic vrd(input logic [2:0] i, input width_e w);
    @(negedge CLOCK_I) VEC_RD_I = {1'b1, i, w};
    @(negedge CLOCK_I) VEC_RD_I.en = 1'b0;
  endtask : vrd
  task automatic cs(input cs_op_e op, input logic [31:0] d);
    @(negedge CLOCK_I) CS_OP_I = op;
    CS_WR_DATA_I = d;
    @(negedge CLOCK_I) CS_OP_I = CS_NONE;
  endtask : cs
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // ==========================================================================
  // tests
  initial begin
    {VEC_WR_I, VEC_RD_I, PI_WR_I, GP_WR_I, CS_WR_DATA_I, CMP_FLAGS_I} = '0;
    {EXC_SET_I, CMP_VALID_I, EXC_FLAGS_I, PI_RD_IDX_I, GP_RD_IDX_I} = '0;
    CS_OP_I = CS_NONE;
    repeat (12) @(posedge CLOCK_I);
    chk("csr reset", 32'h0000_1f80, CS_RD_DATA_O);
    chk("mask reset", 6'h3f, EXC_MASK_O);
    @(negedge CLOCK_I) RESETN_I = 1'b1;
    for (int i = 0; i < 8; i++) vwr(i[2:0], W_128, {16{i[3:0], 4'h5}});
    vwr(3'h2, W_32, 128'h1234_5678);
    vrd(3'h2, W_128);
    chk("vec2", {{12{8'h25}}, 32'h1234_5678}, VEC_RD_DATA_O);
    vrd(3'h2, W_64);
    chk("vec2 w64", {64'h0, 32'h2525_2525, 32'h1234_5678}, VEC_RD_DATA_O);
    for (int i = 0; i < 8; i++) begin
      vrd(i[2:0], W_128);
      if (i != 2) chk("vec", {16{i[3:0], 4'h5}}, VEC_RD_DATA_O);
    end
    vwr(3'h3, W_64, {64'hffff_ffff_ffff_ffff, 64'h0123_4567_89ab_cdef});
    vrd(3'h3, W_128);
    chk("vec3 w64", {{8{8'h35}}, 64'h0123_4567_89ab_cdef}, VEC_RD_DATA_O);
    for (int k = 0; k < 16; k++) ramp[8*k +: 8] = k[7:0];
    vwr(3'h5, W_128, ramp);
    vrd(3'h5, W_128);
    @(negedge CLOCK_I);
    chk("len128", SZ_128, STORE_LEN_O);
    for (int k = 0; k < 16; k++) chk("byte", k[7:0], mem[k]);
    vrd(3'h5, W_32);
    chk("len32", SZ_32, STORE_LEN_O);
    chk("w32", 32'h0302_0100, VEC_RD_DATA_O);
    $display("test vector done");
    cs(CS_LOAD, 32'h0000_e07f);
    chk("csr", 32'h0000_e07f, CS_RD_DATA_O);
    chk("rc", 2'h3, ROUND_CTRL_O);
    chk("fz dz", 2'h3, {FLUSH_ZERO_O, DENORM_ZERO_O});
    chk("fault", 1'b0, GP_FAULT_O);
    for (int j = 0; j < 4; j++) begin
      cs(j[0] ? CS_RESTORE : CS_LOAD, j[1] ? 32'h8000_1f80 : 32'h0001_0000);
      chk("fault", 1'b1, GP_FAULT_O);
      chk("csr kept", 32'h0000_e07f, CS_RD_DATA_O);
    end
    cs(cs_op_e'(2'h3), 32'h0);
    chk("csr op3", 32'h0000_e07f, CS_RD_DATA_O);
    cs(CS_RESTORE, 32'h0000_1f80);
    @(negedge CLOCK_I) {EXC_SET_I, EXC_FLAGS_I} = 7'h45;
    @(negedge CLOCK_I) EXC_SET_I = 1'b0;
    repeat (3) @(negedge CLOCK_I);
    chk("sticky", 6'h05, EXC_FLAG_O);
    cs(CS_LOAD, 32'h0000_1f80);
    chk("cleared", 6'h00, EXC_FLAG_O);
    $display("test control done");
    @(negedge CLOCK_I) {CMP_VALID_I, CMP_FLAGS_I} = 33'h1_0000_0845;
    PI_WR_I = {1'b1, 3'h4, 64'hfedc_ba98_7654_3210};
    GP_WR_I = {1'b1, 3'h6, 32'h89ab_cdef};
    @(negedge CLOCK_I) {CMP_VALID_I, PI_WR_I.en, GP_WR_I.en} = 3'h0;
    {PI_RD_IDX_I, GP_RD_IDX_I} = 6'h26;
    @(negedge CLOCK_I);
    chk("flags", 32'h0000_0845, FLAGS_REG_O);
    chk("pi", 64'hfedc_ba98_7654_3210, PI_RD_DATA_O);
    chk("gp", 32'h89ab_cdef, GP_RD_DATA_O);
    $display("test side regs done");
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge CLOCK_I);
    err_count++;
    report_and_stop();
  end
endmodule : tb
